/* File: core/stpc_ctrl_bank.sv */
// Synthesizer test and RF path control register bank
`timescale 1ns/1ps
`default_nettype none
`include "stpc_regs.svh"
module stpc_ctrl_bank
  import stpc_pkg::*;
#(
  parameter int ADDR_W = 9,
  parameter int LOCK_BASE = `STPC_LOCK_BASE_CYCLES
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Register access from the serial port
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wr_data,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  // Calibration engine
  input wire logic [2:0] i_cal_readback_source,
  input wire logic [15:0] i_core_band_value,
  input wire logic [15:0] i_temp_value,
  input wire logic i_cal_update,
  input wire logic i_conv_enable,
  input wire logic [5:0] i_test_sources,
  // Lock detect
  input wire logic i_cmp_valid,
  input wire logic i_cmp_good,
  input wire logic [1:0] i_lock_count_base,
  // Analog controls
  output logic o_test_out,
  output logic [2:0] o_cal_test_signal_select,
  output logic [3:0] o_tune_target_select,
  output logic [7:0] o_cal_offset,
  output logic [1:0] o_pump_test_mode,
  output logic o_conv_clk_on,
  output logic o_feedback_divider_powerdown,
  output logic o_lock_count_short,
  output logic o_rf_bias_powerdown,
  output logic [2:0] o_if_amplifier_powerdown,
  output logic o_mixer_path_select,
  output logic o_if_input_switch_on
);
  if (ADDR_W < 9) begin : g_addr_check
    $error("ADDR_W must reach 0x100");
  end
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [8:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction : hit

  stpc_byte_t test_tune, next_test_tune;
  stpc_byte_t cal_offset, next_cal_offset;
  stpc_byte_t pump_test, next_pump_test;
  stpc_byte_t div_lock, next_div_lock;
  stpc_byte_t rf_path, next_rf_path;
  logic [15:0] osc_data_value, next_osc_data_value;
  logic [7:0] next_rd_data;
  logic lock_indication;

  // Register writes; read-only locations have no write path
  always_comb begin
    next_test_tune = test_tune;
    next_cal_offset = cal_offset;
    next_pump_test = pump_test;
    next_div_lock = div_lock;
    next_rf_path = rf_path;
    if (i_wr_en) begin
      if (hit(i_addr, `STPC_OFS_TEST_TUNE)) begin
        next_test_tune = i_wr_data & `STPC_TEST_TUNE_WMASK;
      end
      if (hit(i_addr, `STPC_OFS_CAL_OFFSET)) begin
        next_cal_offset = i_wr_data;
      end
      if (hit(i_addr, `STPC_OFS_PUMP_TEST)) begin
        next_pump_test = i_wr_data;
      end
      if (hit(i_addr, `STPC_OFS_DIV_LOCK)) begin
        next_div_lock = i_wr_data;
      end
      if (hit(i_addr, `STPC_OFS_RF_PATH)) begin
        next_rf_path = i_wr_data;
      end
    end
  end

  // Readback capture follows the calibration source selector
  always_comb begin
    next_osc_data_value = osc_data_value;
    if (i_cal_update) begin
      case (i_cal_readback_source)
        `STPC_SEL_CORE_BAND: next_osc_data_value = i_core_band_value;
        `STPC_SEL_TEMP: next_osc_data_value = i_temp_value;
        default: next_osc_data_value = 16'h0000;
      endcase
    end
  end

  // Read data; unmapped reads return zero
  always_comb begin
    next_rd_data = 8'h00;
    if (i_rd_en) begin
      if (hit(i_addr, `STPC_OFS_TEST_TUNE)) next_rd_data = test_tune;
      if (hit(i_addr, `STPC_OFS_CAL_OFFSET)) next_rd_data = cal_offset;
      if (hit(i_addr, `STPC_OFS_PUMP_TEST)) next_rd_data = pump_test;
      if (hit(i_addr, `STPC_OFS_OSC_LOW)) begin
        next_rd_data = osc_data_value[7:0];
      end
      if (hit(i_addr, `STPC_OFS_OSC_HIGH)) begin
        next_rd_data = osc_data_value[15:8];
      end
      if (hit(i_addr, `STPC_OFS_DIV_LOCK)) next_rd_data = div_lock;
      if (hit(i_addr, `STPC_OFS_LOCK_STAT)) begin
        next_rd_data = {7'h00, lock_indication};
      end
      if (hit(i_addr, `STPC_OFS_RF_PATH)) next_rd_data = rf_path;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      test_tune <= `STPC_RST_TEST_TUNE;
      cal_offset <= `STPC_RST_CAL_OFFSET;
      pump_test <= `STPC_RST_PUMP_TEST;
      div_lock <= `STPC_RST_DIV_LOCK;
      rf_path <= `STPC_RST_RF_PATH;
      osc_data_value <= 16'h0000;
      o_rd_data <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      test_tune <= next_test_tune;
      cal_offset <= next_cal_offset;
      pump_test <= next_pump_test;
      div_lock <= next_div_lock;
      rf_path <= next_rf_path;
      osc_data_value <= next_osc_data_value;
      o_rd_data <= next_rd_data;
      o_rd_valid <= i_rd_en;
    end
  end

  // Analog control outputs, registered from the next values
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cal_test_signal_select <= 3'h0;
      o_tune_target_select <= 4'h0;
      o_cal_offset <= 8'h00;
      o_pump_test_mode <= 2'h0;
      o_conv_clk_on <= 1'b1;
      o_feedback_divider_powerdown <= 1'b0;
      o_lock_count_short <= 1'b0;
      o_rf_bias_powerdown <= 1'b0;
      o_if_amplifier_powerdown <= 3'h0;
      o_mixer_path_select <= 1'b1;
      o_if_input_switch_on <= 1'b1;
    end else begin
      o_cal_test_signal_select <= next_test_tune[6:4];
      o_tune_target_select <= next_test_tune[3:0];
      o_cal_offset <= next_cal_offset;
      o_pump_test_mode <= next_pump_test[3:2];
      o_conv_clk_on <= i_conv_enable
                       || !next_div_lock[`STPC_BIT_CLK_DISABLE];
      o_feedback_divider_powerdown <= next_div_lock[`STPC_BIT_DIV_PD];
      o_lock_count_short <= next_div_lock[`STPC_BIT_LOCK_SHORT];
      o_rf_bias_powerdown <= next_rf_path[`STPC_BIT_BIAS_PD];
      o_if_amplifier_powerdown <= next_rf_path[5:3];
      o_mixer_path_select <= next_rf_path[`STPC_BIT_MIXER];
      o_if_input_switch_on <= next_rf_path[`STPC_BIT_IF_SW];
    end
  end

  stpc_test_mux u_test_mux (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_select(test_tune[6:4]),
    .i_sources(i_test_sources),
    .o_test_out(o_test_out)
  );

  stpc_lock_counter #(
    .BASE_CYCLES(LOCK_BASE)
  ) u_lock (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_cmp_valid(i_cmp_valid),
    .i_cmp_good(i_cmp_good),
    .i_lock_count_base(i_lock_count_base),
    .i_lock_count_short(div_lock[`STPC_BIT_LOCK_SHORT]),
    .o_lock_indication(lock_indication)
  );

  // Bus and output checks
  a_offset_write: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_wr_en && hit(i_addr, `STPC_OFS_CAL_OFFSET)) |=>
      o_cal_offset == $past(i_wr_data))
    else $error("offset write not applied");
  a_select_write: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_wr_en && hit(i_addr, `STPC_OFS_TEST_TUNE)) |=>
      {1'b0, o_cal_test_signal_select, 4'h0} == ($past(i_wr_data) & 8'h70))
    else $error("test selector write not applied");
  a_tune_write: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_wr_en && hit(i_addr, `STPC_OFS_TEST_TUNE)) |=>
      {4'h0, o_tune_target_select} == ($past(i_wr_data) & 8'h0F))
    else $error("tune target write not applied");
  a_reserved_zero: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_rd_en && hit(i_addr, `STPC_OFS_TEST_TUNE)) |=> !o_rd_data[7])
    else $error("reserved selector bit read as one");
  a_pump_write: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_wr_en && hit(i_addr, `STPC_OFS_PUMP_TEST)) |=>
      {4'h0, o_pump_test_mode, 2'h0} == ($past(i_wr_data) & 8'h0C))
    else $error("pump mode mismatch");
  a_clk_override: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_conv_enable |=> o_conv_clk_on)
    else $error("converter enable did not force clock on");
  a_clk_gate_off: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (!i_conv_enable && div_lock[`STPC_BIT_CLK_DISABLE] && !i_wr_en) |=>
      !o_conv_clk_on)
    else $error("clock not gated");
  a_divider_write: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_wr_en && hit(i_addr, `STPC_OFS_DIV_LOCK)) |=>
      {6'h00, o_feedback_divider_powerdown, 1'b0} ==
      ($past(i_wr_data) & 8'h02))
    else $error("divider power-down write not applied");
  a_short_write: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_wr_en && hit(i_addr, `STPC_OFS_DIV_LOCK)) |=>
      {7'h00, o_lock_count_short} == ($past(i_wr_data) & 8'h01))
    else $error("lock count select write not applied");
  a_status_read: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_rd_en && hit(i_addr, `STPC_OFS_LOCK_STAT)) |=>
      o_rd_valid && o_rd_data == {7'h00, $past(lock_indication)})
    else $error("status read mismatch");
  a_osc_low_read: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_rd_en && hit(i_addr, `STPC_OFS_OSC_LOW)) |=>
      {8'h00, o_rd_data} == ($past(osc_data_value) & 16'h00FF))
    else $error("readback low byte mismatch");
  a_osc_high_read: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_rd_en && hit(i_addr, `STPC_OFS_OSC_HIGH)) |=>
      {o_rd_data, 8'h00} == ($past(osc_data_value) & 16'hFF00))
    else $error("readback high byte mismatch");
  a_ro_stable: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    !i_cal_update |=> $stable(osc_data_value))
    else $error("readback changed without update");
  a_ro_write: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_wr_en && (hit(i_addr, `STPC_OFS_OSC_LOW) ||
     hit(i_addr, `STPC_OFS_OSC_HIGH) || hit(i_addr, `STPC_OFS_LOCK_STAT)))
      |=> $stable({test_tune, cal_offset, pump_test, div_lock, rf_path}))
    else $error("write to read-only location changed a register");
  a_core_src: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_cal_update && i_cal_readback_source == `STPC_SEL_CORE_BAND) |=>
      osc_data_value == $past(i_core_band_value))
    else $error("core and band readback not captured");
  a_temp_src: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_cal_update && i_cal_readback_source == `STPC_SEL_TEMP) |=>
      osc_data_value == $past(i_temp_value))
    else $error("temperature readback not captured");
  a_rf_path_out: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_wr_en && hit(i_addr, `STPC_OFS_RF_PATH)) |=>
      {o_rf_bias_powerdown, 5'h00, o_mixer_path_select, 1'b0} ==
      ($past(i_wr_data) & 8'h82))
    else $error("RF bias or mixer output mismatch");
  a_if_amp_out: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_wr_en && hit(i_addr, `STPC_OFS_RF_PATH)) |=>
      {2'h0, o_if_amplifier_powerdown, 3'h0} == ($past(i_wr_data) & 8'h38))
    else $error("IF amplifier output mismatch");
  a_if_switch_out: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_wr_en && hit(i_addr, `STPC_OFS_RF_PATH)) |=>
      {7'h00, o_if_input_switch_on} == ($past(i_wr_data) & 8'h01))
    else $error("IF switch output mismatch");
  a_read_valid: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    o_rd_valid == $past(i_rd_en))
    else $error("read valid not one cycle after strobe");
  // Coverage of the main scenarios
  c_core_capture: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cal_update && i_cal_readback_source == `STPC_SEL_CORE_BAND);
  c_path_write: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    i_wr_en && hit(i_addr, `STPC_OFS_RF_PATH));
  c_osc_read: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    i_rd_en && hit(i_addr, `STPC_OFS_OSC_HIGH) && osc_data_value != 16'h0);
  c_clk_gated: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    !o_conv_clk_on);
endmodule : stpc_ctrl_bank
`default_nettype wire

/* File: core/stpc_regs.svh */
// Register offsets, fields, resets and timing counts for the control bank
// Contract
// - Test selector bits 6:4 of 0x039 routes an internal signal to test out.
// - Tune target bits 3:0 select one of sixteen evenly rising voltages.
// - Eight-bit calibration converter offset held at 0x03A, reset zero.
// - Pump test field bits 3:2: 00 tristates pump, 11 pumps normally.
// - Sixteen-bit oscillator readback, low at 0x06E, high at 0x06F.
// - Bit 2 of 0x073 gates converter clock; converter enable overrides it.
// - Bit 1 of 0x073 powers feedback divider down when set.
// - Lock count nominal 1024..8192 cycles, divided by 32 when short.
// - Bit 0 of 0x07C reports lock indication; bits 7:1 read zero.
// - In 0x100, bit 7 powers RF bias down, bit 1 enables mixer.
// - IF amplifier field bits 5:3: 000 powers up, 111 powers down.
// - Bit 0 of 0x100 enables IF input switch, resets to one.
// - Readback source follows selector: 001 core and band, 101 temperature.
`ifndef STPC_REGS_SVH
`define STPC_REGS_SVH
`define STPC_OFS_TEST_TUNE 9'h039
`define STPC_OFS_CAL_OFFSET 9'h03A
`define STPC_OFS_PUMP_TEST 9'h03E
`define STPC_OFS_OSC_LOW 9'h06E
`define STPC_OFS_OSC_HIGH 9'h06F
`define STPC_OFS_DIV_LOCK 9'h073
`define STPC_OFS_LOCK_STAT 9'h07C
`define STPC_OFS_RF_PATH 9'h100
`define STPC_RST_TEST_TUNE 8'h00
`define STPC_RST_CAL_OFFSET 8'h00
`define STPC_RST_PUMP_TEST 8'h00
`define STPC_RST_DIV_LOCK 8'h00
`define STPC_RST_RF_PATH 8'h03
`define STPC_TEST_TUNE_WMASK 8'h7F
`define STPC_BIT_CLK_DISABLE 2
`define STPC_BIT_DIV_PD 1
`define STPC_BIT_LOCK_SHORT 0
`define STPC_BIT_BIAS_PD 7
`define STPC_BIT_MIXER 1
`define STPC_BIT_IF_SW 0
`define STPC_LOCK_BASE_CYCLES 1024
`define STPC_LOCK_SHORT_DIV 32
`define STPC_SEL_CORE_BAND 3'h1
`define STPC_SEL_TEMP 3'h5
`endif

/* File: core/stpc_pkg.sv */
// Types shared by the control bank modules
`default_nettype none
package stpc_pkg;
  typedef enum logic [2:0] {
    STPC_MUX_BUSY = 3'h0,
    STPC_MUX_N_BAND = 3'h1,
    STPC_MUX_R_BAND = 3'h2,
    STPC_MUX_RESERVED = 3'h3,
    STPC_MUX_TIMEOUT_CLK = 3'h4,
    STPC_MUX_BIAS_MIN = 3'h5,
    STPC_MUX_CONV_BUSY = 3'h6,
    STPC_MUX_LOW = 3'h7
  } stpc_mux_e;
  typedef enum logic [1:0] {
    STPC_LK_IDLE = 2'h0,
    STPC_LK_COUNT = 2'h1,
    STPC_LK_LOCKED = 2'h2
  } stpc_lock_e;
  typedef logic [7:0] stpc_byte_t;
endpackage : stpc_pkg
`default_nettype wire

/* File: core/stpc_lock_counter.sv */
// Lock detect counter: declares lock after a run of good comparisons
`timescale 1ns/1ps
`default_nettype none
`include "stpc_regs.svh"
module stpc_lock_counter
  import stpc_pkg::*;
#(
  parameter int BASE_CYCLES = `STPC_LOCK_BASE_CYCLES
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_cmp_valid,
  input wire logic i_cmp_good,
  input wire logic [1:0] i_lock_count_base,
  input wire logic i_lock_count_short,
  // Status
  output logic o_lock_indication
);
  if (BASE_CYCLES < `STPC_LOCK_SHORT_DIV
      || BASE_CYCLES > 2047) begin : g_base_check
    $error("BASE_CYCLES out of range for the lock counter");
  end
  function automatic logic [13:0] lock_target(input logic [1:0] base,
                                               input logic short_sel);
    logic [13:0] full;
    full = 14'(BASE_CYCLES) << base;
    return short_sel ? 14'(full / `STPC_LOCK_SHORT_DIV) : full;
  endfunction : lock_target
  stpc_lock_e state, next_state;
  logic [13:0] count, next_count;
  logic [13:0] target;
  always_comb begin
    target = lock_target(i_lock_count_base, i_lock_count_short);
    next_state = state;
    next_count = count;
    case (state)
      STPC_LK_IDLE: begin
        next_count = 14'h0000;
        if (i_cmp_valid && i_cmp_good) begin
          next_state = STPC_LK_COUNT;
          next_count = 14'h0001;
        end
      end
      STPC_LK_COUNT: begin
        if (i_cmp_valid && !i_cmp_good) begin
          next_state = STPC_LK_IDLE;
        end else if (count >= target) begin
          next_state = STPC_LK_LOCKED;
        end else if (i_cmp_valid) begin
          next_count = count + 14'h0001;
        end
      end
      STPC_LK_LOCKED: begin
        if (i_cmp_valid && !i_cmp_good) begin
          next_state = STPC_LK_IDLE;
        end
      end
      default: next_state = STPC_LK_IDLE;
    endcase
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= STPC_LK_IDLE;
      count <= 14'h0000;
      o_lock_indication <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      o_lock_indication <= (next_state == STPC_LK_LOCKED);
    end
  end
  a_lock_needs_run: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_lock_indication) |-> $past(count) >= $past(target))
    else $error("lock declared before count reached");
  a_bad_drops_lock: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_cmp_valid && !i_cmp_good) |=> !o_lock_indication)
    else $error("lock held after bad comparison");
  c_lock_seen: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_lock_indication));
endmodule : stpc_lock_counter
`default_nettype wire

/* File: core/stpc_test_mux.sv */
// Calibration test output selector
`timescale 1ns/1ps
`default_nettype none
module stpc_test_mux
  import stpc_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Select and sources
  input wire logic [2:0] i_select,
  input wire logic [5:0] i_sources,
  // Output
  output logic o_test_out
);
  logic next_out;
  always_comb begin
    case (stpc_mux_e'(i_select))
      STPC_MUX_BUSY: next_out = i_sources[0];
      STPC_MUX_N_BAND: next_out = i_sources[1];
      STPC_MUX_R_BAND: next_out = i_sources[2];
      STPC_MUX_TIMEOUT_CLK: next_out = i_sources[3];
      STPC_MUX_BIAS_MIN: next_out = i_sources[4];
      STPC_MUX_CONV_BUSY: next_out = i_sources[5];
      default: next_out = 1'b0;
    endcase
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_test_out <= 1'b0;
    end else begin
      o_test_out <= next_out;
    end
  end
  a_low_code_low: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_select == 3'h7) |=> !o_test_out)
    else $error("test out not low for constant low code");
endmodule : stpc_test_mux
`default_nettype wire

/* File: test/test_synth_test_and_path_control_regs.sv */
// Self-checking testbench for the control register bank
`timescale 1ns/1ps
`default_nettype none
`include "stpc_regs.svh"
module test_synth_test_and_path_control_regs;
  import stpc_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst, i_wr_en, i_rd_en, i_cal_update, i_conv_enable;
  logic i_cmp_valid, i_cmp_good, o_rd_valid, o_test_out, o_conv_clk_on;
  logic o_feedback_divider_powerdown, o_lock_count_short, o_rf_bias_powerdown;
  logic o_mixer_path_select, o_if_input_switch_on;
  logic [8:0] i_addr;
  logic [7:0] i_wr_data, o_rd_data, o_cal_offset;
  logic [2:0] i_cal_readback_source, o_cal_test_signal_select;
  logic [2:0] o_if_amplifier_powerdown;
  logic [15:0] i_core_band_value, i_temp_value;
  logic [5:0] i_test_sources;
  logic [1:0] i_lock_count_base, o_pump_test_mode;
  logic [3:0] o_tune_target_select;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;

  stpc_ctrl_bank #(.LOCK_BASE(32)) uut (
    .i_ref_clk, .i_rst, .i_wr_en, .i_rd_en, .i_addr, .i_wr_data, .o_rd_data,
    .o_rd_valid, .i_cal_readback_source, .i_core_band_value, .i_temp_value,
    .i_cal_update, .i_conv_enable, .i_test_sources, .i_cmp_valid,
    .i_cmp_good, .i_lock_count_base, .o_test_out, .o_cal_test_signal_select,
    .o_tune_target_select, .o_cal_offset, .o_pump_test_mode, .o_conv_clk_on,
    .o_feedback_divider_powerdown, .o_lock_count_short, .o_rf_bias_powerdown,
    .o_if_amplifier_powerdown, .o_mixer_path_select, .o_if_input_switch_on
  );

  always #50 i_ref_clk = ~i_ref_clk;

  // Cuts a hang short
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      results();
    end
  end

  task automatic results;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    i_wr_en = 1'b1;
    i_addr = a;
    i_wr_data = d;
    @(negedge i_ref_clk);
    i_wr_en = 1'b0;
  endtask : wr

  task automatic rchk(input logic [8:0] a, input logic [7:0] exp);
    @(negedge i_ref_clk);
    i_rd_en = 1'b1;
    i_addr = a;
    @(negedge i_ref_clk);
    i_rd_en = 1'b0;
    chk(o_rd_valid, 1'b1);
    chk(o_rd_data, exp);
  endtask : rchk

  task automatic settle;
    repeat (2) @(negedge i_ref_clk);
  endtask : settle

  task automatic t_reset;
    chk(o_conv_clk_on, 1'b1);
    chk({o_mixer_path_select, o_if_input_switch_on}, 2'h3);
    chk({o_rf_bias_powerdown, o_if_amplifier_powerdown}, 4'h0);
    chk({o_pump_test_mode, o_feedback_divider_powerdown}, 3'h0);
    chk({o_cal_test_signal_select, o_tune_target_select}, 7'h00);
    chk({o_test_out, o_lock_count_short}, 2'h0);
    chk(o_cal_offset, 8'h00);
    rchk(`STPC_OFS_TEST_TUNE, 8'h00);
    rchk(`STPC_OFS_CAL_OFFSET, 8'h00);
    rchk(`STPC_OFS_PUMP_TEST, 8'h00);
    rchk(`STPC_OFS_OSC_LOW, 8'h00);
    rchk(`STPC_OFS_OSC_HIGH, 8'h00);
    rchk(`STPC_OFS_DIV_LOCK, 8'h00);
    rchk(`STPC_OFS_LOCK_STAT, 8'h00);
    rchk(`STPC_OFS_RF_PATH, 8'h03);
    rchk(9'h050, 8'h00);
  endtask : t_reset

  // Every selector code and every tune code, with the picked source toggled
  task automatic t_test_mux;
    int idx;
    bit ok;
    for (int t = 0; t < 16; t++) begin
      wr(`STPC_OFS_TEST_TUNE, {1'b1, 3'(t), 4'(t)});
      rchk(`STPC_OFS_TEST_TUNE, {1'b0, 3'(t), 4'(t)});
      chk(o_cal_test_signal_select, 16'(t % 8));
      chk(o_tune_target_select, 16'(t));
      idx = (t % 8 < 3) ? t % 8 : t % 8 - 1;
      ok = (t % 8 != 3) && (t % 8 != 7);
      i_test_sources = ok ? 6'(1 << idx) : 6'h3F;
      settle();
      chk(o_test_out, ok);
      i_test_sources = ~6'(1 << idx);
      settle();
      chk(o_test_out, 1'b0);
    end
  endtask : t_test_mux

  task automatic t_offset_pump;
    wr(`STPC_OFS_CAL_OFFSET, 8'hA5);
    chk(o_cal_offset, 8'hA5);
    rchk(`STPC_OFS_CAL_OFFSET, 8'hA5);
    wr(`STPC_OFS_PUMP_TEST, 8'hFF);
    chk(o_pump_test_mode, 2'h3);
    rchk(`STPC_OFS_PUMP_TEST, 8'hFF);
    wr(`STPC_OFS_PUMP_TEST, 8'h30);
    chk(o_pump_test_mode, 2'h0);
  endtask : t_offset_pump

  task automatic t_div_clk;
    i_conv_enable = 1'b0;
    wr(`STPC_OFS_DIV_LOCK, 8'h04);
    settle();
    chk(o_conv_clk_on, 1'b0);
    i_conv_enable = 1'b1;
    settle();
    chk(o_conv_clk_on, 1'b1);
    i_conv_enable = 1'b0;
    wr(`STPC_OFS_DIV_LOCK, 8'h03);
    settle();
    chk(o_conv_clk_on, 1'b1);
    chk(o_feedback_divider_powerdown, 1'b1);
    chk(o_lock_count_short, 1'b1);
    rchk(`STPC_OFS_DIV_LOCK, 8'h03);
  endtask : t_div_clk

  task automatic t_rf_path;
    wr(`STPC_OFS_RF_PATH, 8'hBC);
    chk({o_rf_bias_powerdown, o_if_amplifier_powerdown}, 4'hF);
    chk({o_mixer_path_select, o_if_input_switch_on}, 2'h0);
    rchk(`STPC_OFS_RF_PATH, 8'hBC);
    wr(`STPC_OFS_RF_PATH, 8'h41);
    chk({o_rf_bias_powerdown, o_if_amplifier_powerdown}, 4'h0);
    chk({o_mixer_path_select, o_if_input_switch_on}, 2'h1);
  endtask : t_rf_path

  task automatic capture(input logic [2:0] sel);
    i_cal_readback_source = sel;
    @(negedge i_ref_clk);
    i_cal_update = 1'b1;
    @(negedge i_ref_clk);
    i_cal_update = 1'b0;
  endtask : capture

  task automatic t_readback;
    i_core_band_value = 16'h1234;
    i_temp_value = 16'hBEEF;
    capture(3'h1);
    rchk(`STPC_OFS_OSC_LOW, 8'h34);
    rchk(`STPC_OFS_OSC_HIGH, 8'h12);
    wr(`STPC_OFS_OSC_LOW, 8'hFF);
    wr(`STPC_OFS_OSC_HIGH, 8'hFF);
    rchk(`STPC_OFS_OSC_LOW, 8'h34);
    rchk(`STPC_OFS_OSC_HIGH, 8'h12);
    capture(3'h5);
    rchk(`STPC_OFS_OSC_LOW, 8'hEF);
    rchk(`STPC_OFS_OSC_HIGH, 8'hBE);
    capture(3'h2);
    rchk(`STPC_OFS_OSC_LOW, 8'h00);
  endtask : t_readback

  // Lock after n good compares; one bad compare drops it
  task automatic t_lock(input logic [1:0] base, input bit short, input int n);
    i_lock_count_base = base;
    wr(`STPC_OFS_DIV_LOCK, {7'h00, short});
    @(negedge i_ref_clk);
    i_cmp_valid = 1'b1;
    i_cmp_good = 1'b0;
    @(negedge i_ref_clk);
    i_cmp_good = 1'b1;
    repeat (n - 4) @(negedge i_ref_clk);
    rchk(`STPC_OFS_LOCK_STAT, 8'h00);
    repeat (6) @(negedge i_ref_clk);
    rchk(`STPC_OFS_LOCK_STAT, 8'h01);
    wr(`STPC_OFS_LOCK_STAT, 8'hFE);
    rchk(`STPC_OFS_LOCK_STAT, 8'h01);
    i_cmp_good = 1'b0;
    @(negedge i_ref_clk);
    i_cmp_valid = 1'b0;
    settle();
    rchk(`STPC_OFS_LOCK_STAT, 8'h00);
  endtask : t_lock

  // Reset in mid-run returns every register and output to its reset value
  task automatic t_mid_reset;
    wr(`STPC_OFS_RF_PATH, 8'h00);
    wr(`STPC_OFS_CAL_OFFSET, 8'h3C);
    @(negedge i_ref_clk);
    i_rst = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    i_rst = 1'b0;
    t_reset();
  endtask : t_mid_reset

  initial begin
    i_rst = 1'b1;
    i_wr_en = 1'b0;
    i_rd_en = 1'b0;
    i_addr = 9'h000;
    i_wr_data = 8'h00;
    i_cal_readback_source = 3'h0;
    i_core_band_value = 16'h0000;
    i_temp_value = 16'h0000;
    i_cal_update = 1'b0;
    i_conv_enable = 1'b0;
    i_test_sources = 6'h00;
    i_cmp_valid = 1'b0;
    i_cmp_good = 1'b0;
    i_lock_count_base = 2'h0;
    repeat (16) @(negedge i_ref_clk);
    i_rst = 1'b0;
    t_reset();
    t_test_mux();
    t_offset_pump();
    t_div_clk();
    t_rf_path();
    t_readback();
    t_lock(2'h1, 1'b0, 64);
    t_lock(2'h3, 1'b1, 8);
    t_lock(2'h2, 1'b0, 128);
    t_mid_reset();
    results();
  end
endmodule : test_synth_test_and_path_control_regs
`default_nettype wire
